// file: inc/pci_master_ctl_pkg.sv
// constants and carrier types for the pci master transaction controls
// assumes a single 10 MHz clock domain shared by bus port and pin logic
package pci_master_ctl_pkg;
    // register addresses (word index on the plain port)
    localparam logic [3:0] addr_port_control = 4'h0;
    localparam logic [3:0] addr_irq_status = 4'h1;
    localparam logic [3:0] addr_irq_mask = 4'h2;
    localparam logic [3:0] addr_state = 4'h3;
    // pci_port_control field positions
    localparam int pos_master_wait_disable = 19;
    localparam int pos_master_counter_enable = 18;
    localparam int pos_reserved17 = 17;
    localparam int pos_sys_error_force = 16;
    localparam int pos_master_terminate_req = 15;
    localparam logic [23:0] port_control_reset = 24'h000000;
    // interrupt status bits
    localparam int irq_serr_pulsed = 0;
    localparam int irq_count_term = 1;
    localparam int irq_soft_term = 2;
    localparam int irq_width = 3;
    localparam logic [2:0] irq_reset = 3'h0;
    // host mode value selecting pci
    localparam logic [2:0] host_mode_pci = 3'h1;
    // master access counter
    localparam int counter_width = 8;
    localparam logic [7:0] counter_terminal_default = 8'h3f;
    localparam logic [7:0] counter_reset = 8'h00;

    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_data = 4'b0010,
        st_wait = 4'b0100,
        st_end = 4'b1000
    } master_state_type;

    // request from the bus port
    typedef struct packed {
        logic [3:0] addr;
        logic [23:0] wdata;
        logic write;
        logic read;
    } reg_req_type;

    // transaction status from the pci engine
    typedef struct packed {
        logic master_active;
        logic target_selected;
        logic data_phase_done;
        logic next_phase_ready;
        logic timeout;
        logic last_phase;
        logic bus_idle;
    } pci_status_type;
endpackage

// file: verilog/pin_sync.sv
// two-flip-flop synchroniser for a group of pin levels
// assumes the destination clock is clk
`timescale 1ns/1ps
module pin_sync #(
    parameter int width = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);
    logic [width-1:0] stage1;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // pin_sync

// file: verilog/pci_master_transaction_control.sv
// pci master transaction controls: wait states, access counter, serr force, terminate
// assumes a pci engine on clk reporting phase status; host mode, flags come from other registers
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module pci_master_transaction_control (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [23:0] reg_rdata,
    // port mode and flags from other registers
    input wire logic [2:0] host_mode_field,
    input wire logic host_active_flag,
    input wire logic master_addr_request,
    input wire logic sys_error_enable,
    input wire logic [7:0] counter_terminal,
    // pci engine status
    input wire pci_master_ctl_pkg::pci_status_type pci_status,
    // pci engine controls
    output logic master_terminate,
    output logic master_abort,
    output logic sys_error_signalled_set,
    // pins, output enables active low
    input wire logic initiator_ready_in,
    output logic initiator_ready_pin,
    output logic initiator_ready_oe_n,
    output logic system_error_pin,
    output logic system_error_oe_n,
    // interrupt
    output logic irq
);
    pci_master_ctl_pkg::reg_req_type req;
    pci_master_ctl_pkg::master_state_type state;
    pci_master_ctl_pkg::master_state_type next_state;
    logic [23:0] pci_port_control;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [2:0] irq_event;
    logic [7:0] access_count;
    logic [1:0] pin_levels;
    logic pci_mode;
    logic wait_disable;
    logic counter_enable;
    logic force_req;
    logic term_req;
    logic serr_agent;
    logic serr_fire;
    logic count_hit;
    logic soft_term;
    logic end_now;
    logic ctl_write;

    assign req = '{addr: reg_addr, wdata: reg_wdata, write: reg_write, read: reg_read};

    // pin side levels are outside this domain
    pin_sync #(
        .width(2)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({initiator_ready_in, host_active_flag}),
        .sync_out(pin_levels)
    );

    assign pci_mode = (host_mode_field == pci_master_ctl_pkg::host_mode_pci);
    assign wait_disable = pci_mode
        & pci_port_control[pci_master_ctl_pkg::pos_master_wait_disable];
    assign counter_enable = pci_mode
        & pci_port_control[pci_master_ctl_pkg::pos_master_counter_enable];
    assign force_req = pci_port_control[pci_master_ctl_pkg::pos_sys_error_force];
    assign term_req = pci_port_control[pci_master_ctl_pkg::pos_master_terminate_req];
    assign ctl_write = req.write && (req.addr == pci_master_ctl_pkg::addr_port_control);

    // serr fires only for an active agent with enable set
    assign serr_agent = pci_status.master_active | pci_status.target_selected;
    assign serr_fire = pci_mode & force_req & sys_error_enable & serr_agent;

    // termination causes while mastering
    assign count_hit = counter_enable
        && (access_count >= counter_terminal);
    assign soft_term = pci_mode & term_req & pci_status.master_active;
    assign end_now = count_hit | soft_term | pci_status.timeout | pci_status.last_phase;

    // register writes; set bits 16/15 only by one, cleared by hardware
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pci_port_control <= pci_master_ctl_pkg::port_control_reset;
        end
        else
        begin
            if (ctl_write)
            begin
                pci_port_control[pci_master_ctl_pkg::pos_master_wait_disable] <=
                    req.wdata[pci_master_ctl_pkg::pos_master_wait_disable];
                pci_port_control[pci_master_ctl_pkg::pos_master_counter_enable] <=
                    req.wdata[pci_master_ctl_pkg::pos_master_counter_enable];
            end
            pci_port_control[pci_master_ctl_pkg::pos_reserved17] <= 1'b0;
            // hardware clear first, a new set wins
            if (serr_fire)
            begin
                pci_port_control[pci_master_ctl_pkg::pos_sys_error_force] <= 1'b0;
            end
            if (ctl_write && req.wdata[pci_master_ctl_pkg::pos_sys_error_force])
            begin
                pci_port_control[pci_master_ctl_pkg::pos_sys_error_force] <= 1'b1;
            end
            if (pci_status.bus_idle)
            begin
                pci_port_control[pci_master_ctl_pkg::pos_master_terminate_req] <= 1'b0;
            end
            if (ctl_write && req.wdata[pci_master_ctl_pkg::pos_master_terminate_req])
            begin
                pci_port_control[pci_master_ctl_pkg::pos_master_terminate_req] <= 1'b1;
            end
        end
    end

    // serr pulse, one clock, and signalled error strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            system_error_pin <= 1'b1;
            system_error_oe_n <= 1'b1;
            sys_error_signalled_set <= 1'b0;
        end
        else
        begin
            system_error_pin <= ~serr_fire;
            system_error_oe_n <= ~serr_fire;
            sys_error_signalled_set <= serr_fire;
        end
    end

    // data phase sequencing for the master
    always_comb
    begin
        next_state = state;
        case (state)
            pci_master_ctl_pkg::st_idle:
            begin
                if (pci_status.master_active)
                begin
                    next_state = pci_master_ctl_pkg::st_data;
                end
            end
            pci_master_ctl_pkg::st_data:
            begin
                if (!pci_status.master_active)
                begin
                    next_state = pci_master_ctl_pkg::st_idle;
                end
                else if (end_now)
                begin
                    next_state = pci_master_ctl_pkg::st_end;
                end
                else if (!pci_status.next_phase_ready)
                begin
                    if (wait_disable)
                    begin
                        next_state = pci_master_ctl_pkg::st_end;
                    end
                    else if (pci_mode)
                    begin
                        next_state = pci_master_ctl_pkg::st_wait;
                    end
                end
            end
            pci_master_ctl_pkg::st_wait:
            begin
                if (!pci_status.master_active)
                begin
                    next_state = pci_master_ctl_pkg::st_idle;
                end
                else if (end_now)
                begin
                    next_state = pci_master_ctl_pkg::st_end;
                end
                else if (pci_status.next_phase_ready)
                begin
                    next_state = pci_master_ctl_pkg::st_data;
                end
            end
            pci_master_ctl_pkg::st_end:
            begin
                if (!pci_status.master_active)
                begin
                    next_state = pci_master_ctl_pkg::st_idle;
                end
            end
            default:
            begin
                next_state = pci_master_ctl_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= pci_master_ctl_pkg::st_idle;
        end
        else
        begin
            state <= next_state;
        end
    end

    // pin and engine controls from state
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            initiator_ready_pin <= 1'b1;
            initiator_ready_oe_n <= 1'b1;
            master_terminate <= 1'b0;
            master_abort <= 1'b0;
        end
        else
        begin
            // low level is asserted; high stretches the phase
            initiator_ready_pin <= (next_state == pci_master_ctl_pkg::st_wait);
            initiator_ready_oe_n <= (next_state == pci_master_ctl_pkg::st_idle);
            master_terminate <= (next_state == pci_master_ctl_pkg::st_end);
            master_abort <= 1'b0;
        end
    end

    // master access counter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            access_count <= pci_master_ctl_pkg::counter_reset;
        end
        else if (state == pci_master_ctl_pkg::st_idle)
        begin
            access_count <= pci_master_ctl_pkg::counter_reset;
        end
        else if (counter_enable && pci_status.data_phase_done && !count_hit)
        begin
            access_count <= access_count + 8'h01;
        end
    end

    // sticky interrupt status, set wins over clear
    assign irq_event[pci_master_ctl_pkg::irq_serr_pulsed] = serr_fire;
    assign irq_event[pci_master_ctl_pkg::irq_count_term] = count_hit
        && (state == pci_master_ctl_pkg::st_data) && end_now;
    assign irq_event[pci_master_ctl_pkg::irq_soft_term] = soft_term
        && (state != pci_master_ctl_pkg::st_end);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_status <= pci_master_ctl_pkg::irq_reset;
            irq_mask <= pci_master_ctl_pkg::irq_reset;
        end
        else
        begin
            if (req.write && (req.addr == pci_master_ctl_pkg::addr_irq_status))
            begin
                irq_status <= (irq_status & ~req.wdata[2:0]) | irq_event;
            end
            else
            begin
                irq_status <= irq_status | irq_event;
            end
            if (req.write && (req.addr == pci_master_ctl_pkg::addr_irq_mask))
            begin
                irq_mask <= req.wdata[2:0];
            end
        end
    end

    assign irq = |(irq_status & irq_mask);

    // read data, valid the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 24'h000000;
        end
        else if (!req.read)
        begin
            reg_rdata <= 24'h000000;
        end
        else if (req.addr == pci_master_ctl_pkg::addr_port_control)
        begin
            reg_rdata <= pci_port_control;
        end
        else if (req.addr == pci_master_ctl_pkg::addr_irq_status)
        begin
            reg_rdata <= {21'h0, irq_status};
        end
        else if (req.addr == pci_master_ctl_pkg::addr_irq_mask)
        begin
            reg_rdata <= {21'h0, irq_mask};
        end
        else if (req.addr == pci_master_ctl_pkg::addr_state)
        begin
            reg_rdata <= {9'h0, master_addr_request, pin_levels, state, access_count};
        end
        else
        begin
            reg_rdata <= 24'h000000;
        end
    end
endmodule // pci_master_transaction_control

// file: tb/pci_bus_model.sv
// far-side pci agent model: runs a master burst on request, stalls on demand
// assumes the block's terminate output ends the burst and frees the bus
`timescale 1ns/1ps
module pci_bus_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // scenario controls
    input wire logic start,
    input wire logic slow,
    input wire logic target_sel,
    // from the block
    input wire logic master_terminate,
    // to the block
    output pci_master_ctl_pkg::pci_status_type pci_status
);
    logic active;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            active <= 1'b0;
        else if (start)
            active <= 1'b1;
        else if (master_terminate)
            active <= 1'b0; // normal completion, bus back to idle
    end
    // a stalling target holds off every phase
    assign pci_status = '{master_active: active, target_selected: target_sel,
        data_phase_done: active && !slow, next_phase_ready: !slow, timeout: 1'b0,
        last_phase: 1'b0, bus_idle: !active};
endmodule // pci_bus_model

// file: tb/pci_master_ctl_props.sv
// concurrent checks on the pci master transaction control ports
// assumes one clock domain; bound onto the top module below
`timescale 1ns/1ps
module pci_master_ctl_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [23:0] reg_rdata,
    // mode and status
    input wire logic [2:0] host_mode_field,
    input wire logic sys_error_enable,
    input wire pci_master_ctl_pkg::pci_status_type pci_status,
    // outputs
    input wire logic master_abort,
    input wire logic sys_error_signalled_set,
    input wire logic initiator_ready_pin,
    input wire logic initiator_ready_oe_n,
    input wire logic system_error_pin,
    input wire logic system_error_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic wait_dis;
    logic pci_mode;
    logic in_wait;
    assign pci_mode = host_mode_field == pci_master_ctl_pkg::host_mode_pci;
    assign in_wait = !initiator_ready_oe_n && initiator_ready_pin;
    // shadow of the wait-disable bit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wait_dis <= 1'b0;
        else if (reg_write && reg_addr == pci_master_ctl_pkg::addr_port_control)
            wait_dis <= reg_wdata[pci_master_ctl_pkg::pos_master_wait_disable];
    end
    sequence s_serr_low;
        !system_error_oe_n && sys_error_signalled_set;
    endsequence
    sequence s_serr_back;
        system_error_pin && system_error_oe_n && !sys_error_signalled_set;
    endsequence
    a_serr_pulse: assert property ($fell(system_error_pin) |-> s_serr_low ##1 s_serr_back)
        else $error("serr pulse shape wrong");
    a_serr_cause: assert property ($fell(system_error_pin) |-> $past(sys_error_enable
        && (pci_status.master_active || pci_status.target_selected)))
        else $error("serr forced without enable or bus role");
    a_serr_mode: assert property ($fell(system_error_pin) |-> $past(pci_mode))
        else $error("serr forced outside pci mode");
    a_sse_with_serr: assert property (sys_error_signalled_set |-> !system_error_pin)
        else $error("signalled error without serr");
    a_no_abort: assert property (!master_abort)
        else $error("master abort raised");
    a_enter_wait: assert property ($rose(in_wait) |-> $past(!pci_status.next_phase_ready))
        else $error("wait state with next phase ready");
    a_wait_ends: assert property (in_wait && pci_status.next_phase_ready
        && pci_status.master_active |=> !in_wait)
        else $error("wait state not ended");
    a_no_wait_dis: assert property (wait_dis && $past(wait_dis) && pci_mode
        && $past(pci_mode) |-> !in_wait)
        else $error("wait state while disabled");
    a_resv_zero: assert property ($past(reg_read) |-> !reg_rdata[17])
        else $error("reserved bit reads one");
    a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 24'h000000)
        else $error("read data outside read slot");
endmodule // pci_master_ctl_props

bind pci_master_transaction_control pci_master_ctl_props u_props (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .host_mode_field(host_mode_field), .sys_error_enable(sys_error_enable),
    .pci_status(pci_status), .master_abort(master_abort),
    .sys_error_signalled_set(sys_error_signalled_set),
    .initiator_ready_pin(initiator_ready_pin), .initiator_ready_oe_n(initiator_ready_oe_n),
    .system_error_pin(system_error_pin), .system_error_oe_n(system_error_oe_n)
);

// file: tb/test_pci_master_transaction_control.sv
// self-checking bench for the pci master transaction controls
// assumes the checker is bound in and the bus model sits on the far side
`timescale 1ns/1ps
module test_pci_master_transaction_control;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [23:0] reg_wdata = 24'h000000;
    logic reg_write = 1'b0, reg_read = 1'b0;
    logic [2:0] host_mode_field = pci_master_ctl_pkg::host_mode_pci;
    logic host_active_flag = 1'b0, master_addr_request = 1'b0, sys_error_enable = 1'b0;
    logic [7:0] counter_terminal = 8'h03;
    logic start = 1'b0, slow = 1'b0, target_sel = 1'b0;
    pci_master_ctl_pkg::pci_status_type pci_status;
    logic [23:0] reg_rdata, rd_val;
    logic master_terminate, master_abort, sse_set, irdy_pin, irdy_oe_n, irdy_wire;
    logic serr_pin, serr_oe_n, irq, seen_wait, seen_term, seen_serr;
    int fails = 0, check_count = 0, cycles = 0;
    always #50 clk = ~clk;
    // initiator ready line is pulled up when released
    assign irdy_wire = irdy_oe_n ? 1'b1 : irdy_pin;
    pci_master_transaction_control uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .host_mode_field(host_mode_field),
        .host_active_flag(host_active_flag), .master_addr_request(master_addr_request),
        .sys_error_enable(sys_error_enable), .counter_terminal(counter_terminal),
        .pci_status(pci_status), .master_terminate(master_terminate),
        .master_abort(master_abort), .sys_error_signalled_set(sse_set),
        .initiator_ready_in(irdy_wire), .initiator_ready_pin(irdy_pin),
        .initiator_ready_oe_n(irdy_oe_n), .system_error_pin(serr_pin),
        .system_error_oe_n(serr_oe_n), .irq(irq));
    pci_bus_model partner (.clk(clk), .rst_n(rst_n), .start(start), .slow(slow),
        .target_sel(target_sel), .master_terminate(master_terminate), .pci_status(pci_status));
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fails++;
            end_of_test();
        end
    end
    task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic check_bit(input string name, input logic exp, input logic got);
        check(name, {23'h0, exp}, {23'h0, got});
    endtask
    task automatic wr(input logic [3:0] a, input logic [23:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic watch(input int n);
        seen_wait = 1'b0;
        seen_term = 1'b0;
        seen_serr = 1'b0;
        repeat (n)
        begin
            @(posedge clk);
            #1;
            if (!irdy_oe_n && irdy_pin) seen_wait = 1'b1;
            if (master_terminate) seen_term = 1'b1;
            if (!serr_pin) seen_serr = 1'b1;
        end
    endtask
    task automatic go;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask
    task automatic test_regs;
        rd(pci_master_ctl_pkg::addr_port_control);
        check("control reset", pci_master_ctl_pkg::port_control_reset, rd_val);
        rd(pci_master_ctl_pkg::addr_irq_status);
        check("status reset", 24'h000000, rd_val);
        rd(pci_master_ctl_pkg::addr_state);
        check("state idle", 24'h002100, rd_val);
        wr(4'h9, 24'hffffff);
        rd(4'h9);
        check("unmapped", 24'h000000, rd_val);
        $display("test_regs done");
    endtask
    task automatic test_serr;
        target_sel <= 1'b1;
        wr(4'h0, 24'h010000);
        watch(4);
        check_bit("serr without enable", 1'b0, seen_serr);
        rd(4'h0);
        check("force held", 24'h010000, rd_val);
        wr(4'h0, 24'h000000);
        rd(4'h0);
        check("zero write ignored", 24'h010000, rd_val);
        host_mode_field <= 3'h0;
        sys_error_enable <= 1'b1;
        watch(4);
        check_bit("serr off pci mode", 1'b0, seen_serr);
        host_mode_field <= pci_master_ctl_pkg::host_mode_pci;
        watch(4);
        check_bit("serr forced", 1'b1, seen_serr);
        rd(4'h0);
        check("force cleared", 24'h000000, rd_val);
        wr(4'h0, 24'h010000);
        @(posedge clk);
        #1 check_bit("serr low", 1'b0, serr_pin);
        check_bit("sse set", 1'b1, sse_set);
        @(posedge clk);
        #1 check_bit("serr one cycle", 1'b1, serr_pin);
        rd(4'h1);
        check("serr status", 24'h000001, rd_val);
        wr(4'h2, 24'h000001);
        #1 check_bit("irq raised", 1'b1, irq);
        wr(4'h1, 24'h000001);
        #1 check_bit("irq cleared", 1'b0, irq);
        wr(4'h2, 24'h000000);
        target_sel <= 1'b0;
        sys_error_enable <= 1'b0;
        $display("test_serr done");
    endtask
    task automatic test_wait;
        go();
        slow <= 1'b1;
        watch(4);
        check_bit("wait inserted", 1'b1, seen_wait);
        check_bit("no early end", 1'b0, seen_term);
        slow <= 1'b0;
        watch(2);
        check_bit("ready again", 1'b0, irdy_wire);
        watch(4);
        check_bit("burst unlimited", 1'b0, seen_term);
        wr(4'h0, 24'h008000);
        watch(4);
        check_bit("soft end", 1'b1, seen_term);
        check_bit("no abort", 1'b0, master_abort);
        rd(4'h0);
        check("terminate cleared", 24'h000000, rd_val);
        rd(4'h1);
        check("soft end status", 24'h000004, rd_val);
        wr(4'h1, 24'h000007);
        $display("test_wait done");
    endtask
    task automatic test_nowait;
        wr(4'h0, 24'h080000);
        go();
        slow <= 1'b1;
        watch(4);
        check_bit("no wait state", 1'b0, seen_wait);
        check_bit("ended instead", 1'b1, seen_term);
        slow <= 1'b0;
        wr(4'h0, 24'h000000);
        wr(4'h1, 24'h000007);
        $display("test_nowait done");
    endtask
    task automatic test_counter;
        master_addr_request <= 1'b1;
        wr(4'h0, 24'h040000);
        master_addr_request <= 1'b0;
        go();
        watch(8);
        check_bit("count end", 1'b1, seen_term);
        rd(4'h1);
        check("count status", 24'h000002, rd_val);
        go();
        watch(2);
        check_bit("count restarted", 1'b0, seen_term);
        watch(6);
        check_bit("count end again", 1'b1, seen_term);
        host_mode_field <= 3'h0;
        go();
        watch(8);
        check_bit("count off pci mode", 1'b0, seen_term);
        host_mode_field <= pci_master_ctl_pkg::host_mode_pci;
        watch(8);
        check_bit("count back", 1'b1, seen_term);
        master_addr_request <= 1'b1;
        wr(4'h0, 24'h000000);
        master_addr_request <= 1'b0;
        wr(4'h1, 24'h000007);
        $display("test_counter done");
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        test_regs();
        test_serr();
        test_wait();
        test_nowait();
        test_counter();
        end_of_test();
    end
endmodule // test_pci_master_transaction_control
